// file: logic/isu_serial_port.sv
// Chosen here: register access over APB.
`include "isu_defines.svh"

module isu_serial_port #(
  parameter int CLK_HZ = `ISU_CLK_HZ,
  parameter int BAUD   = `ISU_BAUD,
  parameter int AW     = `ISU_QUEUE_AW
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] paddr,
  input  logic [31:0] pwdata,
  input  logic [3:0]  pstrb,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        irq,
  input  logic        irda_rxd,
  output logic        irda_txd
);
  import isu_pkg::*;

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Nearest whole cycle per bit keeps the rate error under one percent.
  localparam int          BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int          CW      = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] BIT_LD  = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF_LD = CW'(BIT_CYC / 2 - 1);
  localparam logic [AW:0] DEPTH   = (AW+1)'(1) << AW;

  isu_fifo_if #(.WIDTH(8), .AW(AW)) rx_q ();
  isu_fifo_if #(.WIDTH(8), .AW(AW)) tx_q ();

  logic                  ack;
  logic                  rd_pop;
  logic                  err;
  logic                  acc_first;
  logic                  done;
  logic                  hit_data;
  logic                  hit_ctrl;
  logic                  hit_stat;
  logic                  hit_mask;
  logic                  reg_hit;
  logic                  rx_irq_enable;
  logic                  tx_irq_enable;
  logic                  rx_irq_pending;
  logic                  tx_irq_pending;
  logic [`ISU_EVT_W-1:0] evt_stat;
  logic [`ISU_EVT_W-1:0] evt_mask;
  logic [`ISU_EVT_W-1:0] evt_set;
  logic [AW:0]           rx_after;
  logic [AW:0]           tx_free;
  logic [31:0]           rd_value;
  logic                  rxd_meta;
  logic                  rxd_s;
  logic                  rxd_prev;
  isu_rx_state_t         rx_state;
  logic [CW-1:0]         rx_cnt;
  logic [2:0]            rx_idx;
  logic [7:0]            rx_shift;
  logic                  rx_stop_sample;
  isu_tx_state_t         tx_state;
  logic [CW-1:0]         tx_cnt;
  logic [2:0]            tx_idx;
  logic [7:0]            tx_shift;

  // Counts of 256 do not fit the 8-bit fields, so they read as 255.
  function automatic logic [7:0] sat8(input logic [AW:0] c);
    sat8 = (c > (AW+1)'(8'hFF)) ? 8'hFF : c[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------
  isu_fifo #(.WIDTH(8), .AW(AW)) u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (rx_q.queue)
  );

  isu_fifo #(.WIDTH(8), .AW(AW)) u_tx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (tx_q.queue)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Every transfer waits one cycle so that read data comes from a flop.
  assign acc_first = psel && penable && !ack;
  assign done      = psel && penable && ack;
  assign hit_data  = (paddr == `ISU_DATA_ADDR); // R2
  assign hit_ctrl  = (paddr == `ISU_CTRL_ADDR); // R2
  assign hit_stat  = (paddr == `ISU_EVT_STAT_ADDR);
  assign hit_mask  = (paddr == `ISU_EVT_MASK_ADDR);
  assign reg_hit   = hit_data || hit_ctrl || hit_stat || hit_mask;
  assign pready    = ack;
  assign pslverr   = ack && err;

  // Count reported with a read is the one left after this read's pop.
  assign rx_after = rx_q.empty ? rx_q.count : rx_q.count - (AW+1)'(1'h1); // R7
  assign tx_free  = DEPTH - tx_q.count; // R11

  // Pending bits are levels that drop as soon as the receive count or transmit free count falls back to the threshold.
  assign rx_irq_pending = rx_irq_enable && (rx_q.count > `ISU_IRQ_LEVEL); // R14 R15
  assign tx_irq_pending = tx_irq_enable && (tx_free > `ISU_IRQ_LEVEL); // R14 R15

  // Read multiplexer, sampled into prdata in the first access cycle.
  always_comb
  begin
    rd_value = 32'h00000000;
    if (hit_data)
    begin
      rd_value[`ISU_COUNT_MSB:`ISU_COUNT_LSB] = sat8(rx_after); // R4 R7
      rd_value[`ISU_RVALID_BIT]               = !rx_q.empty; // R6 R8
      rd_value[`ISU_CHAR_MSB:0]               = rx_q.head; // R7
    end
    else if (hit_ctrl)
    begin
      rd_value[`ISU_COUNT_MSB:`ISU_COUNT_LSB] = sat8(tx_free); // R11
      rd_value[`ISU_TX_IRQ_PD_BIT]            = tx_irq_pending; // R15
      rd_value[`ISU_RX_IRQ_PD_BIT]            = rx_irq_pending; // R15
      rd_value[`ISU_TX_IRQ_EN_BIT]            = tx_irq_enable; // R13
      rd_value[`ISU_RX_IRQ_EN_BIT]            = rx_irq_enable; // R13
    end
    else if (hit_stat)
    begin
      rd_value[`ISU_EVT_W-1:0] = evt_stat;
    end
    else if (hit_mask)
    begin
      rd_value[`ISU_EVT_W-1:0] = evt_mask;
    end
  end

  // Bus handshake and read capture.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack    <= 1'h0;
      rd_pop <= 1'h0;
      err    <= 1'h0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ack <= acc_first;
      if (acc_first)
      begin
        err    <= !reg_hit;
        rd_pop <= !pwrite && hit_data && !rx_q.empty;
        prdata <= pwrite ? 32'h00000000 : rd_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Queue access from the bus
  // ----------------------------------------------------------------
  // The pop uses the flag caught with the data, so a character that lands
  // between capture and completion is never popped unseen.
  assign rx_q.pop       = done && !pwrite && hit_data && rd_pop; // R7 R10
  assign tx_q.push      = done && pwrite && hit_data && pstrb[0]; // R9 R12
  assign tx_q.push_data = pwdata[`ISU_CHAR_MSB:0]; // R9

  // ----------------------------------------------------------------
  // Control and event registers
  // ----------------------------------------------------------------
  // Interrupt enables.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_irq_enable <= `ISU_IRQ_EN_RESET;
      tx_irq_enable <= `ISU_IRQ_EN_RESET;
    end
    else if (done && pwrite && hit_ctrl && pstrb[0])
    begin
      rx_irq_enable <= pwdata[`ISU_RX_IRQ_EN_BIT]; // R13
      tx_irq_enable <= pwdata[`ISU_TX_IRQ_EN_BIT]; // R13
    end
  end

  // Sticky events; a new event in the clearing cycle survives the clear.
  always_comb
  begin
    evt_set                   = '0;
    evt_set[`ISU_EVT_RX_OVF]  = rx_q.push && rx_q.full; // R5
    evt_set[`ISU_EVT_TX_DROP] = tx_q.push && tx_q.full; // R12
    evt_set[`ISU_EVT_FRAME]   = rx_stop_sample && !rxd_s;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_stat <= `ISU_EVT_RESET;
      evt_mask <= `ISU_EVT_RESET;
    end
    else
    begin
      if (done && pwrite && hit_stat && pstrb[0])
      begin
        evt_stat <= (evt_stat & ~pwdata[`ISU_EVT_W-1:0]) | evt_set;
      end
      else
      begin
        evt_stat <= evt_stat | evt_set;
      end
      if (done && pwrite && hit_mask && pstrb[0])
      begin
        evt_mask <= pwdata[`ISU_EVT_W-1:0];
      end
    end
  end

  // Single level interrupt, registered to keep the output glitch free.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'h0;
    end
    else
    begin
      irq <= rx_irq_pending || tx_irq_pending || |(evt_stat & evt_mask); // R14
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Two-flop synchroniser; the line idles high.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta <= 1'h1;
      rxd_s    <= 1'h1;
      rxd_prev <= 1'h1;
    end
    else
    begin
      rxd_meta <= irda_rxd;
      rxd_s    <= rxd_meta;
      rxd_prev <= rxd_s;
    end
  end

  assign rx_stop_sample = (rx_state == RX_STOP) && (rx_cnt == '0);
  assign rx_q.push      = rx_stop_sample && rxd_s; // R3 R17
  assign rx_q.push_data = rx_shift;

  // Start edge, half-bit recheck, then one sample per bit at its centre.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_idx   <= 3'h0;
      rx_shift <= 8'h00;
    end
    else
    begin
      case (rx_state)
        RX_IDLE:
        begin
          if (rxd_prev && !rxd_s) // R17
          begin
            rx_cnt   <= HALF_LD;
            rx_state <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_cnt != '0)
          begin
            rx_cnt <= rx_cnt - 1'b1;
          end
          else if (!rxd_s)
          begin
            rx_cnt   <= BIT_LD; // R1
            rx_idx   <= 3'h0;
            rx_state <= RX_DATA;
          end
          else
          begin
            rx_state <= RX_IDLE; // Glitch shorter than half a bit.
          end
        end
        RX_DATA:
        begin
          if (rx_cnt != '0)
          begin
            rx_cnt <= rx_cnt - 1'b1;
          end
          else
          begin
            rx_shift <= {rxd_s, rx_shift[7:1]}; // R1 R17
            rx_cnt   <= BIT_LD;
            rx_idx   <= rx_idx + 1'b1;
            if (rx_idx == 3'h7)
            begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_cnt != '0)
          begin
            rx_cnt <= rx_cnt - 1'b1;
          end
          else
          begin
            rx_state <= RX_IDLE;
          end
        end
        default:
        begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_q.pop = (tx_state == TX_IDLE) && !tx_q.empty; // R16

  // Start bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= TX_IDLE;
      tx_cnt   <= '0;
      tx_idx   <= 3'h0;
      tx_shift <= 8'h00;
      irda_txd <= 1'h1;
    end
    else
    begin
      case (tx_state)
        TX_IDLE:
        begin
          if (!tx_q.empty)
          begin
            tx_shift <= tx_q.head;
            irda_txd <= 1'h0; // R16
            tx_cnt   <= BIT_LD;
            tx_state <= TX_START;
          end
        end
        TX_START:
        begin
          if (tx_cnt != '0)
          begin
            tx_cnt <= tx_cnt - 1'b1;
          end
          else
          begin
            irda_txd <= tx_shift[0]; // R16
            tx_shift <= {1'h0, tx_shift[7:1]};
            tx_idx   <= 3'h0;
            tx_cnt   <= BIT_LD;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tx_cnt != '0)
          begin
            tx_cnt <= tx_cnt - 1'b1;
          end
          else
          begin
            tx_cnt <= BIT_LD;
            if (tx_idx == 3'h7)
            begin
              irda_txd <= 1'h1; // R1
              tx_state <= TX_STOP;
            end
            else
            begin
              irda_txd <= tx_shift[0];
              tx_shift <= {1'h0, tx_shift[7:1]};
              tx_idx   <= tx_idx + 1'b1;
            end
          end
        end
        TX_STOP:
        begin
          if (tx_cnt != '0)
          begin
            tx_cnt <= tx_cnt - 1'b1;
          end
          else
          begin
            tx_state <= TX_IDLE;
          end
        end
        default:
        begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_data_capture;
    psel && penable && !pready && !pwrite && hit_data;
  endsequence

  sequence s_tx_launch;
    tx_state == TX_IDLE && !tx_q.empty;
  endsequence

  a_rx_full_drop: assert property (rx_q.full && rx_q.push && !rx_q.pop |=> $stable(rx_q.count)) // R5
    else $error("Receive push into full queue changed it.");
  a_rx_empty_read: assert property (s_rd_data_capture ##0 rx_q.empty |=> !prdata[`ISU_RVALID_BIT]) // R8
    else $error("Empty read reported a valid character.");
  a_rx_read_pop: assert property (s_rd_data_capture ##0 (!rx_q.empty && !rx_q.push) ##1 !rx_q.push
                                  |=> rx_q.count == $past(rx_q.count, 2) - (AW+1)'(1'h1)) // R7
    else $error("Read of a valid character did not pop once.");
  a_wr_keeps_rx: assert property (done && pwrite && !rx_q.push |=> $stable(rx_q.count)) // R10
    else $error("Register write disturbed the receive queue.");
  a_tx_full_drop: assert property (tx_q.full && tx_q.push && !tx_q.pop |=> $stable(tx_q.count)) // R12
    else $error("Write into full transmit queue was stored.");
  a_irq_threshold: assert property (rx_irq_enable && rx_q.count > `ISU_IRQ_LEVEL ##1 rx_irq_enable |-> irq) // R14
    else $error("Receive threshold interrupt missing.");
  a_tx_launch_start: assert property (s_tx_launch |=> !irda_txd && tx_state == TX_START) // R16
    else $error("Idle transmitter did not start a frame.");
  a_tx_stop_high: assert property (tx_state == TX_STOP |-> irda_txd) // R1
    else $error("Stop bit driven low.");
  a_rx_stop_accept: assert property (rx_q.push |-> rx_state == RX_STOP && rxd_s) // R17
    else $error("Character accepted without a high stop bit.");
  a_bus_unmapped: assert property (acc_first && !reg_hit |=> pready && pslverr) // R2
    else $error("Unmapped address answered without error.");
endmodule

// file: logic/isu_defines.svh
// Summary of operation
// R1: Frame is 8N1 at 115200 baud.
// R2: Data and control registers at fixed addresses.
// R3: Received characters enter a 256-entry queue.
// R4: Data bits 23:16 show receive fill count.
// R5: Character arriving at full receive queue is dropped.
// R6: Data bit 15 flags a readable character.
// R7: Data read pops oldest, returns decremented count.
// R8: Empty read shows valid clear, character undefined.
// R9: Data write pushes character into transmit queue.
// R10: Data write leaves receive side untouched.
// R11: Control bits 23:16 show transmit free count.
// R12: Write to full transmit queue is dropped.
// R13: Control holds receive and transmit interrupt enables.
// R14: Interrupts assert while count exceeds 31.
// R15: Pending bits follow their queue conditions.
// R16: Idle transmitter sends next queued character.
// R17: Receiver centre-samples, needs high stop bit.
`ifndef ISU_DEFINES_SVH
`define ISU_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ISU_DATA_ADDR     32'hFF201020
`define ISU_CTRL_ADDR     32'hFF201024
`define ISU_EVT_STAT_ADDR 32'hFF201028
`define ISU_EVT_MASK_ADDR 32'hFF20102C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISU_CHAR_MSB      7
`define ISU_RVALID_BIT    15
`define ISU_COUNT_LSB     16
`define ISU_COUNT_MSB     23
`define ISU_RX_IRQ_EN_BIT 0
`define ISU_TX_IRQ_EN_BIT 1
`define ISU_RX_IRQ_PD_BIT 8
`define ISU_TX_IRQ_PD_BIT 9
`define ISU_EVT_RX_OVF    0
`define ISU_EVT_TX_DROP   1
`define ISU_EVT_FRAME     2
`define ISU_EVT_W         3

// ----------------------------------------------------------------
// Reset values, thresholds and timing
// ----------------------------------------------------------------
`define ISU_IRQ_EN_RESET  1'h0
`define ISU_EVT_RESET     3'h0
`define ISU_IRQ_LEVEL     9'h01F
`define ISU_QUEUE_AW      8
`define ISU_CLK_HZ        20000000
`define ISU_BAUD          115200

`endif

// file: logic/isu_pkg.sv
package isu_pkg;

  // Transmitter sequencing.
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} isu_tx_state_t;

  // Receiver sequencing.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} isu_rx_state_t;

endpackage

// file: logic/isu_fifo_if.sv
interface isu_fifo_if #(
  parameter int WIDTH = 8,
  parameter int AW    = 8
);
  logic             push;
  logic [WIDTH-1:0] push_data;
  logic             pop;
  logic [WIDTH-1:0] head;
  logic             full;
  logic             empty;
  logic [AW:0]      count;

  modport owner (output push, push_data, pop, input head, full, empty, count);
  modport queue (input push, push_data, pop, output head, full, empty, count);
endinterface

// file: logic/isu_fifo.sv
module isu_fifo #(
  parameter int WIDTH = 8,
  parameter int AW    = 8
) (
  input logic         pclk,
  input logic         presetn,
  isu_fifo_if.queue   q
);
  import isu_pkg::*;

  localparam logic [AW:0] DEPTH = (AW+1)'(1) << AW;

  logic [WIDTH-1:0] mem [2**AW];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push_ok;
  logic             pop_ok;

  // A push into a full queue is refused here, so stored contents never change.
  assign push_ok = q.push && (count != DEPTH); // R5 R12
  assign pop_ok  = q.pop && (count != '0);

  // Storage has no reset; only slots under the count are ever read as valid.
  always_ff @(posedge pclk)
  begin
    if (push_ok)
    begin
      mem[wr_ptr] <= q.push_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push_ok)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_ok)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    end
  end

  // Status toward the owner.
  assign q.head  = mem[rd_ptr];
  assign q.count = count;
  assign q.full  = (count == DEPTH);
  assign q.empty = (count == '0);

  a_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn) count <= DEPTH)
    else $error("Queue count exceeds depth.");
endmodule

// file: dv/isu_ir_xcvr.sv
module isu_ir_xcvr #(
  parameter int BIT = 10
) (
  input  logic       pclk,
  input  logic       irda_txd,
  output logic       irda_rxd,
  output logic       got,
  output logic [8:0] got_frame
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] c;

  // --------------------
  // Sender toward the port
  // --------------------
  // The line rests high between frames; a low stop bit is sent only when
  // a scenario asks for a fault.
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      irda_rxd <= f[i];
      repeat (BIT) @(posedge pclk);
    end
    irda_rxd <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // --------------------
  // Receiver of port frames
  // --------------------
  // Bits are taken mid-cell on the falling clock edge, clear of the edge
  // on which the port moves its line.
  initial
  begin
    irda_rxd  = 1'b1;
    got       = 1'b0;
    got_frame = 9'h000;
    forever
    begin
      @(negedge irda_txd);
      repeat (BIT / 2) @(negedge pclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(negedge pclk);
        c[i] = irda_txd;
      end
      repeat (BIT) @(negedge pclk);
      got_frame <= {irda_txd, c};
      got       <= 1'b1;
      @(negedge pclk);
      got       <= 1'b0;
    end
  end
endmodule

// file: dv/testbench.sv
`include "isu_defines.svh"

`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((e) !== (g)) \
    begin \
      fail_count++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // --------------------
  // Signals and notes
  // --------------------
  localparam int          BIT    = 10;
  localparam logic [33:0] M_ALL  = 34'h3FFFFFFFF;
  localparam logic [33:0] M_NOCH = 34'h3FFFFFF00;
  localparam logic [33:0] M_WR   = 34'h100000000;
  localparam logic [33:0] M_CTL  = 34'h300000103;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        irda_rxd;
  logic        irda_txd;
  logic        got;
  logic [8:0]  got_frame;
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];
  logic [8:0]  tx_q[$];
  logic [7:0]  rx_q[$];
  logic [33:0] ev;
  logic [33:0] mk;
  logic [8:0]  tv;
  logic [7:0]  ch;
  logic        lossy;
  int          drops;
  int          fail_count;
  int          samples_checked;
  int          seed;

  // Ten-cycle bits keep a full queue of frames short.
  isu_serial_port #(
    .BAUD(2000000)
  ) u_isu_serial_port (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (4'h1),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .irq      (irq),
    .irda_rxd (irda_rxd),
    .irda_txd (irda_txd)
  );

  isu_ir_xcvr #(
    .BIT(BIT)
  ) xcvr (
    .pclk      (pclk),
    .irda_txd  (irda_txd),
    .irda_rxd  (irda_rxd),
    .got       (got),
    .got_frame (got_frame)
  );

  // Free-running 50 ns clock.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // --------------------
  // Bus master
  // --------------------
  // One idle cycle follows each transfer so psel is never driven twice
  // in one time step.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [33:0] e, input logic [33:0] m);
    int n;
    n = 0;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      complete_run();
    end
    else
    begin
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h000000000, M_WR);
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e, input logic [33:0] m);
    apb(1'b0, a, 32'h00000000, e, m);
  endtask

  function automatic logic [33:0] dx(input logic i, input logic [7:0] n, input logic [7:0] c);
    return {i, 9'h000, n, 8'h80, c};
  endfunction

  // Result watcher: irq, error and read data at each completion, and
  // every frame the transceiver decodes. While writes may be dropped,
  // skipped notes are counted as drops.
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      ev = exp_q.pop_front();
      mk = msk_q.pop_front();
      `CHK("apb", ev, {irq, pslverr, prdata} & mk)
    end
    if (got === 1'b1)
    begin
      tv = (tx_q.size() > 0) ? tx_q.pop_front() : 9'h000;
      while (lossy && tv !== got_frame && tx_q.size() > 0)
      begin
        tv = tx_q.pop_front();
        drops++;
      end
      `CHK("txd", tv, got_frame)
    end
  end

  // Watchdog against a hang.
  initial
  begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    seed = 8;
    fail_count = 0;
    samples_checked = 0;
    drops = 0;
    lossy = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ISU_CTRL_ADDR, 34'h000FF0000, M_ALL);
    rd(`ISU_DATA_ADDR, 34'h000000000, M_NOCH);
    rd(`ISU_DATA_ADDR + 32'h10, 34'h100000000, M_ALL);
    apb(1'b1, `ISU_DATA_ADDR + 32'h10, 32'h0, 34'h100000000, M_WR);
    xcvr.send(8'h5A, 1'b0);
    repeat (BIT) @(posedge pclk);
    rd(`ISU_DATA_ADDR, 34'h000000000, M_NOCH);
    rd(`ISU_EVT_STAT_ADDR, 34'h000000004, M_ALL);
    wr(`ISU_EVT_MASK_ADDR, 32'h4);
    rd(`ISU_EVT_STAT_ADDR, 34'h200000004, M_ALL);
    wr(`ISU_EVT_STAT_ADDR, 32'h4);
    rd(`ISU_EVT_STAT_ADDR, 34'h000000000, M_ALL);
    wr(`ISU_EVT_MASK_ADDR, 32'h0);
    $display("test map_and_framing done");
    for (int i = 0; i < 3; i++)
    begin
      ch = 8'($random(seed));
      rx_q.push_back(ch);
      xcvr.send(ch, 1'b1);
    end
    repeat (BIT) @(posedge pclk);
    ch = 8'($random(seed));
    tx_q.push_back({1'b1, ch});
    wr(`ISU_DATA_ADDR, {24'h000000, ch});
    for (int i = 2; i >= 0; i--)
      rd(`ISU_DATA_ADDR, dx(1'b0, 8'(i), rx_q.pop_front()), M_ALL);
    $display("test echo done");
    lossy = 1'b1;
    fork
      for (int i = 0; i < 257; i++)
      begin
        ch = 8'($random(seed));
        if (i < 256)
          rx_q.push_back(ch);
        xcvr.send(ch, 1'b1);
      end
      for (int i = 0; i < 300; i++)
      begin
        tx_q.push_back({1'b1, 8'(i)});
        wr(`ISU_DATA_ADDR, 32'(i));
      end
    join
    repeat (BIT) @(posedge pclk);
    rd(`ISU_EVT_STAT_ADDR, 34'h000000003, M_ALL);
    wr(`ISU_CTRL_ADDR, 32'h1);
    rd(`ISU_CTRL_ADDR, 34'h200000101, M_CTL);
    for (int i = 0; i < 256; i++)
      rd(`ISU_DATA_ADDR, dx(i < 225, 8'(255 - i), rx_q.pop_front()), M_ALL);
    rd(`ISU_CTRL_ADDR, 34'h000000001, M_CTL);
    rd(`ISU_DATA_ADDR, 34'h000000000, M_NOCH);
    repeat (30000) @(posedge pclk);
    wr(`ISU_CTRL_ADDR, 32'h2);
    rd(`ISU_CTRL_ADDR, 34'h200FF0202, M_ALL);
    `CHK("dropped", 1'b1, (drops + tx_q.size()) > 0)
    $display("test full_queues done");
    complete_run();
  end
endmodule
